// *** hdl/arc_cfg.svh ***
// constants of the alternator regulator configuration bank
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

`define ARC_CLK_MHZ 20
`define ARC_ADDR_THERM 8'h00
`define ARC_ADDR_VOLT 8'h04
`define ARC_ADDR_CURR 8'h08
`define ARC_ADDR_PRE 8'h0c
`define ARC_ADDR_CTRL 8'h10
`define ARC_ADDR_STAT 8'h14
`define ARC_CTRL_COMMIT 0
`define ARC_THERM_RST 32'h0000_1880
`define ARC_VOLT_RST 32'h000e_8036
`define ARC_CURR_RST 32'h0000_860c
`define ARC_PRE_RST 32'h0000_0107

`define ARC_TEMP_BASE_C 120
`define ARC_TEMP_STEP_C 4
`define ARC_TMAX_BASE_C 160
`define ARC_CLAMP_TEMP_C 176
`define ARC_KN_LAST 4'ha
`define ARC_SLOPE_LAST 4'hd
`define ARC_SLOPE_STEP_MV 50
`define ARC_GRAD_QMVS 200
`define ARC_IFILT_BASE_MS 180
`define ARC_IFILT_STEP_MS 20
`define ARC_IFILT_WRAP 4'h8
`define ARC_IFILT_LAST 4'he

`define ARC_OV_BASE_DV 165
`define ARC_OV_STEP_DV 5
`define ARC_OV_OFF 2'h3
`define ARC_LV_CUSTOM 3'h7
`define ARC_LV_TABLE {11'd1100, 11'd1050, 11'd1025, 11'd1000, 11'd975, 11'd925, 11'd875}
`define ARC_FILT0_US 520
`define ARC_FILT1_US 780
`define ARC_FILT2_US 1040
`define ARC_FILT3_US 1200
`define ARC_PREEXC_PCT 8

`define ARC_DUTY_FULL 128
`define ARC_DUTY_TOP 126

`define ARC_OVR_IMAX 2'h1
`define ARC_OVR_TABLE {14'd12000, 14'd11000, 14'd0, 14'd13000}
`define ARC_IMAX_NONE 3'h7
`define ARC_IMAX_TABLE {14'd0, 14'd13000, 14'd12000, 14'd11000, 14'd10000, 14'd8000, 14'd7000, 14'd6000}
`define ARC_CORR_TABLE {9'sd200, 9'sd150, 9'sd100, 9'sd50, 9'sd150, 9'sd100, 9'sd50, 9'sd0}
`define ARC_CORR_NEG 3'h4
`define ARC_ITAU_NUM 320
`define ARC_ITAU_DEN 3
`define ARC_PGAIN_NUM 3175
`define ARC_PV_STEP_MA 100
`define ARC_PV_ADJ_MA 200
`define ARC_PV_NONE 2'h3
`define ARC_PV_MINUS 2'h1
`define ARC_PV_PLUS 2'h2

`endif

// *** hdl/arc_pkg.sv ***
// types of the alternator regulator configuration bank
package arc_pkg;
    typedef struct packed {
        logic [12:0] pad;
        logic [1:0] grad;
        logic [3:0] slope;
        logic [1:0] kn_max;
        logic clamp_en;
        logic [3:0] kn;
        logic shift_en;
        logic comp_dis;
        logic [3:0] ifilt;
    } arc_therm_t;
    typedef struct packed {
        logic [10:0] pad;
        logic [2:0] ceil;
        logic [2:0] floor;
        logic special_en;
        logic zero_en;
        logic [1:0] excitation_pwm_frequency;
        logic lv_rec;
        logic lv_dis;
        logic [1:0] lv_t;
        logic [2:0] lv_thr;
        logic [1:0] ov_t;
        logic [1:0] ov_thr;
    } arc_volt_t;
    typedef struct packed {
        logic [9:0] pad;
        logic dec2;
        logic [6:0] pgain;
        logic [4:0] igain;
        logic legacy;
        logic [2:0] corr;
        logic [2:0] imax;
        logic [1:0] ovr;
    } arc_curr_t;
    typedef struct packed {
        logic [16:0] pad;
        logic [6:0] ppre;
        logic [5:0] pv_val;
        logic [1:0] pv_sel;
    } arc_pre_t;
    typedef struct packed {
        arc_therm_t therm;
        arc_volt_t volt;
        arc_curr_t curr;
        arc_pre_t pre;
    } arc_image_t;
    typedef struct packed {
        logic comp_en;
        logic setpoint_clamp;
        logic [7:0] start_c;
        logic [9:0] slope_mv;
        logic [7:0] grad_qmvs;
        logic [8:0] ifilt_ms;
    } arc_therm_set_t;
    typedef struct packed {
        logic [7:0] ov_dv;
        logic [10:0] lv_cv;
        logic overvoltage;
        logic low_voltage;
        logic recovery_ramp;
        logic [1:0] excitation_pwm_frequency;
        logic special_en;
        logic [3:0] preexc_pct;
    } arc_volt_set_t;
    typedef struct packed {
        logic legacy;
        logic unlimited;
        logic [14:0] limit_ma;
        logic int_dis;
        logic [11:0] int_tau_ms;
        logic [11:0] p_reg_ma;
        logic [11:0] p_pre_ma;
        logic pv_unlimited;
        logic [12:0] pv_limit_ma;
        logic duty_decrement;
    } arc_curr_set_t;
endpackage : arc_pkg

// *** hdl/arc_regulator_config.sv ***
// configuration bank and setting decode of the alternator field regulator
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "arc_cfg.svh"

module arc_regulator_config
    import arc_pkg::*;
#(
    parameter int FILT0_CYC = `ARC_FILT0_US * `ARC_CLK_MHZ,
    parameter int FILT1_CYC = `ARC_FILT1_US * `ARC_CLK_MHZ,
    parameter int FILT2_CYC = `ARC_FILT2_US * `ARC_CLK_MHZ,
    parameter int FILT3_CYC = `ARC_FILT3_US * `ARC_CLK_MHZ,
    parameter logic [10:0] LV_CUSTOM_CV = 11'd1000
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [4:0] i_lin_shift_c,
    input wire logic [7:0] i_junction_temp_c,
    input wire logic i_lin_limit_valid,
    input wire logic [14:0] i_lin_limit_ma,
    input wire logic i_ov_above,
    input wire logic i_lv_below,
    input wire logic i_supply_above_lim,
    input wire logic [7:0] i_loop_duty,
    input wire logic i_limiting,
    input wire logic i_reg_period_tick,
    output logic o_cfg_ready,
    output arc_therm_set_t o_thermal,
    output arc_volt_set_t o_voltage,
    output arc_curr_set_t o_current,
    output logic [7:0] o_exc_duty
);
    localparam logic [76:0] LV_TBL = `ARC_LV_TABLE;
    localparam logic [55:0] OVR_TBL = `ARC_OVR_TABLE;
    localparam logic [111:0] IMAX_TBL = `ARC_IMAX_TABLE;
    localparam logic [71:0] CORR_TBL = `ARC_CORR_TABLE;

    arc_image_t shadow_q, shadow_d, act_q, act_d;
    logic loaded_q, loaded_d, invalid_q, invalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] sync1_q, sync2_q;
    logic [1:0] det_w, en_w, raw_w;
    logic [1:0] code_w [2];
    arc_therm_set_t therm_q, therm_d;
    arc_volt_set_t volt_q, volt_d;
    arc_curr_set_t curr_q, curr_d;
    logic [7:0] duty_q, duty_d;
    logic dec_ph_q, dec_ph_d;

    function automatic logic bad_codes(input arc_image_t im);
        bad_codes = (im.therm.kn > `ARC_KN_LAST)
                  || (im.therm.slope > `ARC_SLOPE_LAST)
                  || (im.therm.ifilt > `ARC_IFILT_LAST)
                  || (im.curr.pgain == 7'h00)
                  || (im.pre.ppre == 7'h00);
    endfunction : bad_codes

    function automatic logic [15:0] filt_cyc(input logic [1:0] code);
        unique case (code)
            2'h0: filt_cyc = 16'(FILT0_CYC);
            2'h1: filt_cyc = 16'(FILT1_CYC);
            2'h2: filt_cyc = 16'(FILT2_CYC);
            2'h3: filt_cyc = 16'(FILT3_CYC);
        endcase
    endfunction : filt_cyc

    function automatic logic [11:0] pgain_ma(input logic [6:0] n);
        pgain_ma = (n == 7'h00) ? 12'h000 : 12'(`ARC_PGAIN_NUM / n);
    endfunction : pgain_ma

    // image is writable only until it is committed; afterwards it is frozen
    always_comb begin
        shadow_d = shadow_q;
        act_d = act_q;
        loaded_d = loaded_q;
        invalid_d = invalid_q;
        rdata_d = 32'h0000_0000;
        if (i_wr && !loaded_q) begin
            case (i_addr)
                `ARC_ADDR_THERM: shadow_d.therm = i_wdata;
                `ARC_ADDR_VOLT: shadow_d.volt = i_wdata;
                `ARC_ADDR_CURR: shadow_d.curr = i_wdata;
                `ARC_ADDR_PRE: shadow_d.pre = i_wdata;
                `ARC_ADDR_CTRL: begin
                    if (i_wdata[`ARC_CTRL_COMMIT]) begin
                        // reserved codes keep the regulator unconfigured
                        if (bad_codes(shadow_q)) begin
                            invalid_d = 1'b1;
                        end else begin
                            act_d = shadow_q;
                            loaded_d = 1'b1;
                            invalid_d = 1'b0;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `ARC_ADDR_THERM: rdata_d = shadow_q.therm;
                `ARC_ADDR_VOLT: rdata_d = shadow_q.volt;
                `ARC_ADDR_CURR: rdata_d = shadow_q.curr;
                `ARC_ADDR_PRE: rdata_d = shadow_q.pre;
                `ARC_ADDR_STAT: rdata_d = {27'h0, volt_q.recovery_ramp,
                    volt_q.low_voltage, volt_q.overvoltage,
                    invalid_q, loaded_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shadow_q <= {`ARC_THERM_RST, `ARC_VOLT_RST, `ARC_CURR_RST,
                `ARC_PRE_RST};
            act_q <= {`ARC_THERM_RST, `ARC_VOLT_RST, `ARC_CURR_RST,
                `ARC_PRE_RST};
            loaded_q <= 1'b0;
            invalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            shadow_q <= shadow_d;
            act_q <= act_d;
            loaded_q <= loaded_d;
            invalid_q <= invalid_d;
            rdata_q <= rdata_d;
        end
    end

    // comparator levels come from the analogue side
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {i_supply_above_lim, i_lv_below, i_ov_above};
            sync2_q <= sync1_q;
        end
    end

    assign en_w = {!act_q.volt.lv_dis, act_q.volt.ov_t != `ARC_OV_OFF};
    assign raw_w = sync2_q[1:0];
    assign code_w[0] = act_q.volt.ov_t;
    assign code_w[1] = act_q.volt.lv_t;

    // index 0 is overvoltage, 1 is low voltage; a glitch restarts the wait
    for (genvar k = 0; k < 2; k++) begin : g_det
        logic [15:0] cnt_q, cnt_d;
        logic det_q, det_d;
        always_comb begin
            cnt_d = cnt_q;
            det_d = det_q;
            if (!en_w[k] || !raw_w[k]) begin
                cnt_d = 16'h0000;
                det_d = 1'b0;
            end else if (cnt_q >= filt_cyc(code_w[k]) - 16'h0001) begin
                det_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                cnt_q <= 16'h0000;
                det_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                det_q <= det_d;
            end
        end
        assign det_w[k] = det_q;
    end

    logic [7:0] t_base, t_max;
    logic [8:0] t_shift;
    logic [7:0] d_lo, d_hi;
    logic [13:0] i_base;
    logic signed [15:0] i_corr;
    logic [14:0] i_nvm;
    logic signed [14:0] pv_s;

    always_comb begin
        therm_d = therm_q;
        volt_d = volt_q;
        curr_d = curr_q;
        // thermal compensation settings
        therm_d.comp_en = !act_q.therm.comp_dis;
        t_base = 8'(`ARC_TEMP_BASE_C + `ARC_TEMP_STEP_C * act_q.therm.kn);
        t_max = 8'(`ARC_TMAX_BASE_C
            + `ARC_TEMP_STEP_C * act_q.therm.kn_max);
        t_shift = {1'b0, t_base}
            + (act_q.therm.shift_en ? {4'h0, i_lin_shift_c} : 9'h000);
        therm_d.start_c = (t_shift > {1'b0, t_max}) ? t_max
            : t_shift[7:0];
        therm_d.setpoint_clamp = act_q.therm.clamp_en
            && (i_junction_temp_c > 8'(`ARC_CLAMP_TEMP_C));
        therm_d.slope_mv = 10'(`ARC_SLOPE_STEP_MV
            * (act_q.therm.slope + 1));
        therm_d.grad_qmvs = 8'(`ARC_GRAD_QMVS >> act_q.therm.grad);
        if (act_q.therm.ifilt < `ARC_IFILT_WRAP) begin
            therm_d.ifilt_ms = 9'(`ARC_IFILT_BASE_MS
                + `ARC_IFILT_STEP_MS * act_q.therm.ifilt);
        end else begin
            therm_d.ifilt_ms = 9'(`ARC_IFILT_STEP_MS
                * (act_q.therm.ifilt - 7));
        end
        // voltage monitoring settings
        volt_d.ov_dv = 8'(`ARC_OV_BASE_DV
            + `ARC_OV_STEP_DV * act_q.volt.ov_thr);
        volt_d.lv_cv = (act_q.volt.lv_thr == `ARC_LV_CUSTOM) ? LV_CUSTOM_CV
            : LV_TBL[act_q.volt.lv_thr * 11 +: 11];
        volt_d.overvoltage = det_w[0];
        volt_d.low_voltage = det_w[1];
        volt_d.recovery_ramp = act_q.volt.lv_rec
            && volt_q.low_voltage && !det_w[1];
        volt_d.excitation_pwm_frequency = act_q.volt.excitation_pwm_frequency;
        volt_d.special_en = act_q.volt.special_en;
        volt_d.preexc_pct = (act_q.volt.zero_en && sync2_q[2]) ? 4'h0
            : 4'(`ARC_PREEXC_PCT);
        // duty window, bypassed for a full-off or full-on command
        d_lo = 8'(act_q.volt.floor) + 8'h01;
        d_hi = 8'(`ARC_DUTY_TOP) - 8'(act_q.volt.ceil);
        if (i_loop_duty == 8'h00 || i_loop_duty >= 8'(`ARC_DUTY_FULL)) begin
            duty_d = i_loop_duty;
        end else if (i_loop_duty < d_lo) begin
            duty_d = d_lo;
        end else if (i_loop_duty > d_hi) begin
            duty_d = d_hi;
        end else begin
            duty_d = i_loop_duty;
        end
        // current limitation settings
        i_base = (act_q.curr.ovr == `ARC_OVR_IMAX)
            ? IMAX_TBL[act_q.curr.imax * 14 +: 14]
            : OVR_TBL[act_q.curr.ovr * 14 +: 14];
        i_corr = $signed({2'b00, i_base});
        if (act_q.curr.corr >= `ARC_CORR_NEG) begin
            i_corr = i_corr - 16'(CORR_TBL[act_q.curr.corr * 9 +: 9]);
        end else begin
            i_corr = i_corr + 16'(CORR_TBL[act_q.curr.corr * 9 +: 9]);
        end
        i_nvm = (i_corr < 0) ? 15'h0000 : i_corr[14:0];
        curr_d.unlimited = (act_q.curr.ovr == `ARC_OVR_IMAX)
            && (act_q.curr.imax == `ARC_IMAX_NONE) && !i_lin_limit_valid;
        // the stored limit stays the ceiling unless imax selects no limit; then the LIN limit is taken as it is
        if (i_lin_limit_valid && (curr_d.unlimited || i_lin_limit_ma < i_nvm
            || (act_q.curr.ovr == `ARC_OVR_IMAX
            && act_q.curr.imax == `ARC_IMAX_NONE))) begin
            curr_d.limit_ma = i_lin_limit_ma;
        end else begin
            curr_d.limit_ma = i_nvm;
        end
        curr_d.legacy = act_q.curr.legacy;
        curr_d.int_dis = (act_q.curr.igain == 5'h00);
        curr_d.int_tau_ms = 12'(`ARC_ITAU_NUM * act_q.curr.igain
            / `ARC_ITAU_DEN);
        curr_d.p_reg_ma = pgain_ma(act_q.curr.pgain);
        curr_d.p_pre_ma = pgain_ma(act_q.pre.ppre);
        pv_s = 15'(`ARC_PV_STEP_MA * act_q.pre.pv_val);
        if (act_q.pre.pv_sel == `ARC_PV_MINUS) begin
            pv_s = pv_s - 15'(`ARC_PV_ADJ_MA);
        end else if (act_q.pre.pv_sel == `ARC_PV_PLUS) begin
            pv_s = pv_s + 15'(`ARC_PV_ADJ_MA);
        end
        curr_d.pv_limit_ma = (pv_s < 0) ? 13'h0000 : pv_s[12:0];
        curr_d.pv_unlimited = (act_q.pre.pv_sel == `ARC_PV_NONE);
        // legacy scheme steps duty down on regulator period ticks
        dec_ph_d = dec_ph_q;
        curr_d.duty_decrement = 1'b0;
        if (!act_q.curr.legacy || !i_limiting) begin
            dec_ph_d = 1'b0;
        end else if (i_reg_period_tick) begin
            dec_ph_d = act_q.curr.dec2 ? !dec_ph_q : 1'b0;
            curr_d.duty_decrement = !act_q.curr.dec2 || dec_ph_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            therm_q <= '0;
            volt_q <= '0;
            curr_q <= '0;
            duty_q <= 8'h00;
            dec_ph_q <= 1'b0;
        end else begin
            therm_q <= therm_d;
            volt_q <= volt_d;
            curr_q <= curr_d;
            duty_q <= duty_d;
            dec_ph_q <= dec_ph_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_cfg_ready = loaded_q;
    assign o_thermal = therm_q;
    assign o_voltage = volt_q;
    assign o_current = curr_q;
    assign o_exc_duty = duty_q;

    property p_locked;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q |=> (act_q == $past(act_q)) && loaded_q;
    endproperty
    a_locked: assert property (p_locked)
        else $error("configuration changed after commit");

    property p_start_max;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && $past(loaded_q) |-> therm_q.start_c
            <= 8'(`ARC_TMAX_BASE_C + `ARC_TEMP_STEP_C * act_q.therm.kn_max);
    endproperty
    a_start_max: assert property (p_start_max)
        else $error("start temperature above its maximum");

    property p_clamp;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q ##1 1'b1 |-> therm_q.setpoint_clamp == $past(
            act_q.therm.clamp_en && i_junction_temp_c > 8'd176);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("hot setpoint clamp wrong");

    property p_duty_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_loop_duty == 8'h00 |=> o_exc_duty == 8'h00;
    endproperty
    a_duty_zero: assert property (p_duty_zero)
        else $error("zero duty not passed through");

    property p_duty_floor;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && i_loop_duty != 8'h00 && i_loop_duty < 8'd128
            |=> o_exc_duty >= 8'(act_q.volt.floor) + 8'h01;
    endproperty
    a_duty_floor: assert property (p_duty_floor)
        else $error("duty below floor");

    property p_duty_ceil;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && i_loop_duty != 8'h00 && i_loop_duty < 8'd128
            |=> o_exc_duty <= 8'd126 - 8'(act_q.volt.ceil);
    endproperty
    a_duty_ceil: assert property (p_duty_ceil)
        else $error("duty above ceiling");

    property p_ov_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && act_q.volt.ov_t == 2'h3 |-> ##2 !volt_q.overvoltage;
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("overvoltage reported while disabled");

    property p_lv_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && act_q.volt.lv_dis |-> ##2 !volt_q.low_voltage;
    endproperty
    a_lv_off: assert property (p_lv_off)
        else $error("low voltage reported while disabled");

    property p_dec_cause;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(curr_q.duty_decrement) |-> $past(act_q.curr.legacy
            && i_limiting && i_reg_period_tick);
    endproperty
    a_dec_cause: assert property (p_dec_cause)
        else $error("duty decrement without legacy tick");

    property p_dec_slow;
        @(posedge i_clk) disable iff (!i_rst_b)
        loaded_q && act_q.curr.dec2 && curr_q.duty_decrement
            |=> !curr_q.duty_decrement;
    endproperty
    a_dec_slow: assert property (p_dec_slow)
        else $error("decrement faster than every second period");

    c_commit: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(loaded_q));
    c_ov: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(volt_q.overvoltage));
    c_recov: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        volt_q.recovery_ramp);
    c_dec: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        curr_q.duty_decrement ##2 curr_q.duty_decrement);
endmodule : arc_regulator_config
`default_nettype wire

// *** bench/arc_datapath_model.sv ***
// regulator-period tick source for the regulation datapath side
`timescale 1ns/100ps
`default_nettype none
module arc_datapath_model #(
    parameter int PERIOD = 10
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    output logic o_tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    // free running, so ticks keep coming while the bench waits
    always_comb begin
        cnt_d = (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign o_tick = (cnt_q == 8'h00) & i_rst_b;
endmodule : arc_datapath_model
`default_nettype wire

// *** bench/arc_regulator_config_tb_top.sv ***
// self-checking bench of the regulator configuration bank
`timescale 1ns/100ps
`default_nettype none
module arc_regulator_config_tb_top;
    import arc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [4:0] i_lin_shift_c = 5'h00;
    logic [7:0] i_loop_duty = 8'h00;
    logic i_ov_above = 1'b0;
    logic i_limiting = 1'b0;
    logic [7:0] i_junction_temp_c = 8'h00;
    logic i_lv_below = 1'b0;
    logic i_supply_above_lim = 1'b0;
    logic tick;
    logic ready;
    logic [31:0] rdata;
    logic [7:0] duty;
    arc_therm_set_t th;
    arc_volt_set_t vo;
    arc_curr_set_t cu;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    always #25 i_clk = ~i_clk;
    arc_datapath_model #(.PERIOD(10)) partner (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .o_tick(tick));
    // short filter counts keep the run brief
    arc_regulator_config #(.FILT0_CYC(8), .FILT1_CYC(12), .FILT2_CYC(16),
        .FILT3_CYC(20)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(rdata), .i_lin_shift_c(i_lin_shift_c),
        .i_junction_temp_c(i_junction_temp_c), .i_lin_limit_valid(1'b0),
        .i_lin_limit_ma(15'h0000), .i_ov_above(i_ov_above),
        .i_lv_below(i_lv_below), .i_supply_above_lim(i_supply_above_lim),
        .i_loop_duty(i_loop_duty), .i_limiting(i_limiting),
        .i_reg_period_tick(tick), .o_cfg_ready(ready), .o_thermal(th),
        .o_voltage(vo), .o_current(cu), .o_exc_duty(duty));
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 ck(rdata, e);
    endtask : rd
    task automatic t_defaults;
        logic [31:0] ex [5] = '{32'h1880, 32'he8036, 32'h860c, 32'h107, 0};
        for (int k = 0; k < 5; k++) begin
            rd(8'(k * 4 + (k / 4) * 16), ex[k]);
        end
        ck(32'(th.start_c), 32'd128);
        ck(32'(th.comp_en), 32'd1);
        ck(32'(vo.ov_dv), 32'd175);
        ck(32'(vo.lv_cv), 32'd1000);
        ck(32'(cu.limit_ma), 32'd13000);
        ck(32'(cu.p_reg_ma), 32'd1587);
        ck(32'(cu.int_tau_ms), 32'd320);
        $display("end defaults");
    endtask : t_defaults
    task automatic t_duty;
        logic [7:0] in [4] = '{8'd3, 8'd0, 8'd128, 8'd127};
        logic [7:0] ex [4] = '{8'd6, 8'd0, 8'd128, 8'd123};
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            i_loop_duty <= in[k];
            repeat (2) @(posedge i_clk);
            #1 ck(32'(duty), 32'(ex[k]));
        end
        $display("end duty");
    endtask : t_duty
    task automatic t_commit;
        wr(8'h00, 32'h2e0);
        wr(8'h10, 32'h1);
        rd(8'h14, 32'h2);
        wr(8'h00, 32'h220);
        wr(8'h04, 32'he8032);
        wr(8'h08, 32'h870c);
        i_lin_shift_c <= 5'd4;
        wr(8'h10, 32'h1);
        rd(8'h14, 32'h1);
        ck(32'(th.start_c), 32'd156);
        ck(32'(cu.legacy), 32'd1);
        i_lin_shift_c <= 5'd12;
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h220);
        ck(32'(th.start_c), 32'd160);
        $display("end commit");
    endtask : t_commit
    task automatic t_ov;
        int n = 0;
        @(posedge i_clk);
        i_ov_above <= 1'b1;
        while (vo.overvoltage !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1 n++;
        end
        ck(32'(n >= 8 && n <= 14), 32'd1);
        i_ov_above <= 1'b0;
        repeat (5) @(posedge i_clk);
        ck(32'(vo.overvoltage), 32'd0);
        $display("end overvoltage");
    endtask : t_ov
    // committed image has clamp and zero duty off, low voltage filter 8
    task automatic t_lv;
        @(posedge i_clk);
        i_lv_below <= 1'b1;
        i_junction_temp_c <= 8'd200;
        i_supply_above_lim <= 1'b1;
        repeat (16) @(posedge i_clk);
        #1 ck(32'(vo.low_voltage), 32'd1);
        ck(32'(th.setpoint_clamp), 32'd0);
        ck(32'(vo.preexc_pct), 32'd8);
        @(posedge i_clk);
        i_lv_below <= 1'b0;
        i_supply_above_lim <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1 ck(32'(vo.low_voltage), 32'd0);
        $display("end low voltage");
    endtask : t_lv
    task automatic t_dec;
        int n = 0;
        @(posedge i_clk);
        i_limiting <= 1'b1;
        repeat (40) begin
            @(posedge i_clk);
            #1 n += (cu.duty_decrement === 1'b1);
        end
        ck(32'(n >= 3 && n <= 4), 32'd1);
        $display("end decrement");
    endtask : t_dec
    task automatic wrap_up;
        $display("checks %0d bad %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // ceiling well above the roughly 140 cycles the tests need
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_defaults;
        t_duty;
        t_commit;
        t_ov;
        t_lv;
        t_dec;
        wrap_up;
    end
endmodule : arc_regulator_config_tb_top
`default_nettype wire
